// ### rtl/backup_rail_pkg.sv
// constants and types for the backup charger and backup rail control
package backup_rail_pkg;
	localparam int CODE_W = 4;
	localparam int RAIL_W = 2;
	localparam int CUR_HIGH_UA = 60; // run current
	localparam int CUR_LOW_UA = 10; // standby and quiet-off current
	localparam logic CUR_SEL_HIGH = 1'b1;
	localparam logic CUR_SEL_LOW = 1'b0;
	localparam logic [1:0] RAIL_OFF = 2'h0;
	localparam logic [1:0] RAIL_1V8 = 2'h1;
	localparam logic [1:0] RAIL_3V0 = 2'h2;
	localparam logic [1:0] RAIL_3V3 = 2'h3;
	// target voltage in tens of millivolts, per charge target code
	localparam logic [8:0] TARGET_CV_1V8 = 9'h0B4;
	localparam logic [8:0] TARGET_CV_2V0 = 9'h0C8;
	localparam logic [8:0] TARGET_CV_STEP = 9'h00A;
	localparam logic [8:0] TARGET_CV_3V6 = 9'h168;
	localparam logic [3:0] CODE_MAX = 4'hF;
	// rail voltages in tens of millivolts
	localparam logic [8:0] RAIL_CV_1V8 = 9'h0B4;
	localparam logic [8:0] RAIL_CV_3V0 = 9'h12C;
	localparam logic [8:0] RAIL_CV_3V3 = 9'h14A;
	localparam logic [2:0] PS_OTHER = 3'h0;
	typedef enum logic [2:0] {
		PS_OFF_OTHER,
		PS_RUN,
		PS_STANDBY,
		PS_QUIET_OFF
	} power_state_t;
	typedef enum logic [1:0] {
		SRC_NONE,
		SRC_MAIN,
		SRC_CELL
	} rail_source_t;
endpackage

// ### rtl/sync2.sv
// two-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module sync2 #(
	parameter int W = 1
) (
	input wire logic mclk, // system clock
	input wire logic rst, // async reset, active high
	input wire logic [W-1:0] din, // asynchronous levels
	output logic [W-1:0] dout // synchronised levels
);
	logic [W-1:0] meta;

	// first stage is read only by the second
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			meta <= '0;
			dout <= '0;
		end else begin
			meta <= din;
			dout <= meta;
		end
	end
endmodule // sync2

// ### rtl/backup_charger_rail_control.sv
// control of the backup cell charger and the backup rail
`timescale 1ns/1ps
module backup_charger_rail_control (
	input wire logic mclk, // 250 MHz clock
	input wire logic rst, // async reset, active high
	input wire backup_rail_pkg::power_state_t power_state, // from main state machine
	input wire logic uv_ok_pin, // main supply above undervoltage threshold (analog)
	input wire logic warn_low_pin, // main supply below low-supply warning (analog)
	input wire logic main_above_cell_pin, // main supply higher than cell (analog)
	input wire logic cell_present_pin, // backup cell present (analog)
	input wire logic fuses_loaded, // fuse configuration valid, same clock
	input wire logic [3:0] charge_target_fuse_default, // fuse default of target code
	input wire logic [1:0] backup_rail_voltage_fuse_code, // fuse rail code
	input wire logic [8:0] source_cv, // selected source voltage, tens of mV
	input wire logic wr_system_on_charge_enable, // host write strobe
	input wire logic wr_off_state_charge_enable, // host write strobe
	input wire logic wr_charge_target_code, // host write strobe
	input wire logic wr_backup_rail_voltage_code, // host write strobe
	input wire logic wr_data_bit, // write data for enable bits
	input wire logic [3:0] wr_code, // write data for target code
	input wire logic [1:0] wr_rail_code, // write data for rail code
	output logic system_on_charge_enable, // stored enable bit
	output logic off_state_charge_enable, // stored enable bit
	output logic [3:0] charge_target_code, // stored target code
	output logic [1:0] backup_rail_voltage_code, // stored rail code
	output logic charger_enable, // to analog charger
	output logic charge_current_high, // 1 = 60 uA, 0 = 10 uA
	output logic [8:0] charge_target_cv, // target voltage, tens of mV
	output logic backup_rail_output, // rail enable
	output logic rail_from_main, // rail powered from main supply
	output logic rail_from_cell, // rail powered from cell
	output logic rail_regulate, // 1 regulate, 0 pass switch
	output logic rail_dropout // rail follows its input
);
	logic [3:0] pins_s;
	logic uv_ok;
	logic warn_low;
	logic main_above_cell;
	logic cell_seen;
	logic uv_ok_d;
	logic fuse_pend;
	logic [8:0] rail_cv;

	sync2 #(.W(4)) u_sync (
		.mclk(mclk),
		.rst(rst),
		.din({uv_ok_pin, warn_low_pin, main_above_cell_pin, cell_present_pin}),
		.dout(pins_s)
	);
	assign uv_ok = pins_s[3];
	assign warn_low = pins_s[2];
	assign main_above_cell = pins_s[1];
	assign cell_seen = pins_s[0];

	// charge target code to voltage, 0.1 V steps from code 1 to code 14
	function automatic logic [8:0] target_cv(input logic [3:0] c);
		if (c == 4'h0)
			target_cv = backup_rail_pkg::TARGET_CV_1V8;
		else if (c == backup_rail_pkg::CODE_MAX)
			target_cv = backup_rail_pkg::TARGET_CV_3V6;
		else
			target_cv = backup_rail_pkg::TARGET_CV_2V0
				+ 9'(({5'h0, c} - 9'h001) * backup_rail_pkg::TARGET_CV_STEP);
	endfunction

	// supply crossing in either direction
	wire uv_cross = uv_ok ^ uv_ok_d;
	wire in_run = power_state == backup_rail_pkg::PS_RUN;
	wire in_stby = power_state == backup_rail_pkg::PS_STANDBY;
	wire in_quiet = power_state == backup_rail_pkg::PS_QUIET_OFF;
	wire sys_on = in_run || in_stby;
	// off-state bit matters only in quiet off; others stay off
	wire next_chg_en = sys_on ? system_on_charge_enable :
		(in_quiet ? off_state_charge_enable : 1'b0);
	wire next_cur_high = in_run && system_on_charge_enable;
	wire rail_cfg_on = backup_rail_voltage_code != backup_rail_pkg::RAIL_OFF;
	// the one fuse load owed after reset, and any cycle that rewrites the fields
	wire fuse_load = fuse_pend && uv_ok && fuses_loaded;
	wire reload_now = uv_cross || fuse_load;
	// rail waits for a valid supply and loaded fuses
	wire rail_ready = !fuse_pend && fuses_loaded;
	wire use_main = uv_ok && !warn_low ? 1'b1 : main_above_cell;
	wire src_valid = use_main ? uv_ok || warn_low : cell_seen;
	wire next_rail_on = rail_cfg_on && rail_ready && src_valid;
	wire next_reg = use_main || backup_rail_voltage_code == backup_rail_pkg::RAIL_1V8;

	// rail code to voltage
	always_comb begin
		unique case (backup_rail_voltage_code)
			backup_rail_pkg::RAIL_1V8: rail_cv = backup_rail_pkg::RAIL_CV_1V8;
			backup_rail_pkg::RAIL_3V0: rail_cv = backup_rail_pkg::RAIL_CV_3V0;
			backup_rail_pkg::RAIL_3V3: rail_cv = backup_rail_pkg::RAIL_CV_3V3;
			default: rail_cv = 9'h000;
		endcase
	end

	// edge history; the fuse load is owed once after reset only, because a
	// crossing reloads the codes directly and must not drop a cell-fed rail
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			uv_ok_d <= 1'b0;
			fuse_pend <= 1'b1;
		end else begin
			uv_ok_d <= uv_ok;
			if (fuse_load)
				fuse_pend <= 1'b0;
		end
	end

	// configuration bits; supply crossing overrides host writes
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			system_on_charge_enable <= 1'b0;
			off_state_charge_enable <= 1'b0;
			charge_target_code <= 4'h0;
			backup_rail_voltage_code <= 2'h0;
		end else if (reload_now) begin
			system_on_charge_enable <= 1'b0;
			off_state_charge_enable <= 1'b0;
			charge_target_code <= charge_target_fuse_default;
			backup_rail_voltage_code <= backup_rail_voltage_fuse_code;
		end else begin
			if (wr_system_on_charge_enable)
				system_on_charge_enable <= wr_data_bit;
			if (wr_off_state_charge_enable)
				off_state_charge_enable <= wr_data_bit;
			if (wr_charge_target_code)
				charge_target_code <= wr_code;
			if (wr_backup_rail_voltage_code && sys_on)
				backup_rail_voltage_code <= wr_rail_code;
		end
	end

	// analog control outputs, all registered
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			charger_enable <= 1'b0;
			charge_current_high <= backup_rail_pkg::CUR_SEL_LOW;
			charge_target_cv <= 9'h000;
			backup_rail_output <= 1'b0;
			rail_from_main <= 1'b0;
			rail_from_cell <= 1'b0;
			rail_regulate <= 1'b0;
			rail_dropout <= 1'b0;
		end else begin
			charger_enable <= next_chg_en;
			charge_current_high <= next_cur_high;
			charge_target_cv <= target_cv(charge_target_code);
			backup_rail_output <= next_rail_on;
			rail_from_main <= next_rail_on && use_main;
			rail_from_cell <= next_rail_on && !use_main;
			rail_regulate <= next_rail_on && next_reg;
			rail_dropout <= next_rail_on && rail_cv > source_cv;
		end
	end

	property p_run_high;
		@(posedge mclk) disable iff (rst)
		(in_run && system_on_charge_enable) |=> (charger_enable && charge_current_high);
	endproperty
	a_run_high: assert property (p_run_high) else $error("run charge not high");

	property p_stby_low;
		@(posedge mclk) disable iff (rst)
		in_stby |=> !charge_current_high && charger_enable == $past(system_on_charge_enable);
	endproperty
	a_stby_low: assert property (p_stby_low) else $error("standby charge wrong");

	property p_quiet;
		@(posedge mclk) disable iff (rst)
		in_quiet |=> !charge_current_high && charger_enable == $past(off_state_charge_enable);
	endproperty
	a_quiet: assert property (p_quiet) else $error("quiet-off charge wrong");

	property p_other_off;
		@(posedge mclk) disable iff (rst)
		!(sys_on || in_quiet) |=> !charger_enable;
	endproperty
	a_other_off: assert property (p_other_off) else $error("charger on in other state");

	property p_cross_clear;
		@(posedge mclk) disable iff (rst)
		uv_cross |=> !system_on_charge_enable && !off_state_charge_enable;
	endproperty
	a_cross_clear: assert property (p_cross_clear) else $error("enables not cleared");

	property p_cross_reload;
		@(posedge mclk) disable iff (rst)
		uv_cross |=> backup_rail_voltage_code == $past(backup_rail_voltage_fuse_code)
			&& charge_target_code == $past(charge_target_fuse_default);
	endproperty
	a_cross_reload: assert property (p_cross_reload) else $error("fuses not reloaded");

	property p_rail_wait;
		@(posedge mclk) disable iff (rst)
		fuse_pend |=> !backup_rail_output;
	endproperty
	a_rail_wait: assert property (p_rail_wait) else $error("rail on before fuse load");

	sequence s_cfg_off;
		!rail_cfg_on ##1 1'b1;
	endsequence
	property p_code_off;
		@(posedge mclk) disable iff (rst)
		s_cfg_off |-> !backup_rail_output;
	endproperty
	a_code_off: assert property (p_code_off) else $error("rail on with code off");

	property p_cell_mode;
		@(posedge mclk) disable iff (rst)
		(next_rail_on && !use_main) |=>
			rail_from_cell && rail_regulate == ($past(backup_rail_voltage_code) == 2'h1);
	endproperty
	a_cell_mode: assert property (p_cell_mode) else $error("cell mode wrong");

	// host writes land unless a reload takes the same cycle; rail code writes also need run or standby
	property p_sys_write;
		@(posedge mclk) disable iff (rst)
		(wr_system_on_charge_enable && !reload_now) |=>
			system_on_charge_enable == $past(wr_data_bit);
	endproperty
	a_sys_write: assert property (p_sys_write) else $error("sys-on bit write lost");

	property p_off_write;
		@(posedge mclk) disable iff (rst)
		(wr_off_state_charge_enable && !reload_now) |=>
			off_state_charge_enable == $past(wr_data_bit);
	endproperty
	a_off_write: assert property (p_off_write) else $error("off-state bit write lost");

	property p_target_write;
		@(posedge mclk) disable iff (rst)
		(wr_charge_target_code && !reload_now) |=>
			charge_target_code == $past(wr_code);
	endproperty
	a_target_write: assert property (p_target_write) else $error("target write lost");

	property p_rail_write;
		@(posedge mclk) disable iff (rst)
		(wr_backup_rail_voltage_code && sys_on && !reload_now) |=>
			backup_rail_voltage_code == $past(wr_rail_code);
	endproperty
	a_rail_write: assert property (p_rail_write) else $error("rail code write lost");

	property p_rail_refuse;
		@(posedge mclk) disable iff (rst)
		(!sys_on && !reload_now) |=> $stable(backup_rail_voltage_code);
	endproperty
	a_rail_refuse: assert property (p_rail_refuse) else $error("rail code changed off");

	property p_fuse_first;
		@(posedge mclk) disable iff (rst)
		fuse_load |=> charge_target_code == $past(charge_target_fuse_default)
			&& backup_rail_voltage_code == $past(backup_rail_voltage_fuse_code);
	endproperty
	a_fuse_first: assert property (p_fuse_first) else $error("fuse defaults not taken");

	// once loaded, later crossings never hold the rail off again
	property p_pend_sticky;
		@(posedge mclk) disable iff (rst)
		!fuse_pend |=> !fuse_pend;
	endproperty
	a_pend_sticky: assert property (p_pend_sticky) else $error("fuse load owed again");

	property p_run_follow;
		@(posedge mclk) disable iff (rst)
		(in_run && !system_on_charge_enable) |=> !charger_enable;
	endproperty
	a_run_follow: assert property (p_run_follow) else $error("charger on with bit clear");

	property p_code_low;
		@(posedge mclk) disable iff (rst)
		(charge_target_code == 4'h0) |=> charge_target_cv == backup_rail_pkg::TARGET_CV_1V8;
	endproperty
	a_code_low: assert property (p_code_low) else $error("lowest target wrong");

	property p_code_top;
		@(posedge mclk) disable iff (rst)
		(charge_target_code == backup_rail_pkg::CODE_MAX) |=>
			charge_target_cv == backup_rail_pkg::TARGET_CV_3V6;
	endproperty
	a_code_top: assert property (p_code_top) else $error("highest target wrong");

	property p_one_source;
		@(posedge mclk) disable iff (rst)
		!(rail_from_main && rail_from_cell)
			&& ((rail_from_main || rail_from_cell) == backup_rail_output);
	endproperty
	a_one_source: assert property (p_one_source) else $error("rail source select wrong");

	property p_off_idle;
		@(posedge mclk) disable iff (rst)
		!backup_rail_output |-> !rail_regulate && !rail_dropout;
	endproperty
	a_off_idle: assert property (p_off_idle) else $error("rail mode set while off");

	property p_dropout_3v3;
		@(posedge mclk) disable iff (rst)
		(next_rail_on && backup_rail_voltage_code == backup_rail_pkg::RAIL_3V3
			&& source_cv < backup_rail_pkg::RAIL_CV_3V3) |=> rail_dropout;
	endproperty
	a_dropout_3v3: assert property (p_dropout_3v3) else $error("no dropout at 3.3 V");

	property p_no_dropout;
		@(posedge mclk) disable iff (rst)
		(next_rail_on && source_cv >= backup_rail_pkg::RAIL_CV_3V3) |=> !rail_dropout;
	endproperty
	a_no_dropout: assert property (p_no_dropout) else $error("dropout with headroom");

	// supply gone, cell higher: the rail carries on from the cell
	property p_cell_keeps;
		@(posedge mclk) disable iff (rst)
		(!fuse_pend && fuses_loaded && rail_cfg_on && !uv_ok && !main_above_cell && cell_seen)
			|=> backup_rail_output && rail_from_cell;
	endproperty
	a_cell_keeps: assert property (p_cell_keeps) else $error("cell-fed rail dropped");

	sequence s_supply_rise;
		!uv_ok ##1 uv_ok;
	endsequence
	property p_rise_main;
		@(posedge mclk) disable iff (rst)
		(s_supply_rise ##0 (!fuse_pend && fuses_loaded && rail_cfg_on && !warn_low))
			|=> backup_rail_output && rail_from_main;
	endproperty
	a_rise_main: assert property (p_rise_main) else $error("rail not on main after rise");
endmodule // backup_charger_rail_control

// ### dv/host_model.sv
// host model that writes the control fields as single-cycle strobes
`timescale 1ns/1ps
module host_model (
	input wire logic mclk, // system clock
	output logic wr_system_on_charge_enable, // write strobe
	output logic wr_off_state_charge_enable, // write strobe
	output logic wr_charge_target_code, // write strobe
	output logic wr_backup_rail_voltage_code, // write strobe
	output logic wr_data_bit, // enable bit data
	output logic [3:0] wr_code, // target code data
	output logic [1:0] wr_rail_code // rail code data
);
	// strobes idle low, data idles at a junk pattern
	initial begin
		{wr_system_on_charge_enable, wr_off_state_charge_enable} = 2'h0;
		{wr_charge_target_code, wr_backup_rail_voltage_code} = 2'h0;
		{wr_data_bit, wr_code, wr_rail_code} = 7'h55;
	end
	// one write: kind 0 sys-on bit, 1 off-state bit, 2 target code, 3 rail code
	// any kind is sent in any power state; the task does not check run or system on
	task automatic put(input logic [1:0] kind, input logic [3:0] d);
		@(negedge mclk);
		wr_data_bit = d[0];
		wr_code = d;
		wr_rail_code = d[1:0];
		wr_system_on_charge_enable = (kind == 2'h0);
		wr_off_state_charge_enable = (kind == 2'h1);
		wr_charge_target_code = (kind == 2'h2);
		wr_backup_rail_voltage_code = (kind == 2'h3);
		@(negedge mclk);
		{wr_system_on_charge_enable, wr_off_state_charge_enable} = 2'h0;
		{wr_charge_target_code, wr_backup_rail_voltage_code} = 2'h0;
		// released data shows the inverse so a late sample cannot pass by luck
		{wr_data_bit, wr_code, wr_rail_code} = ~{d[0], d, d[1:0]};
	endtask
endmodule // host_model

// ### dv/tb_top.sv
// self-checking bench for the backup charger and rail control
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
	$display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
	logic mclk, rst, uv_ok_pin, warn_low_pin, main_above_cell_pin, cell_present_pin;
	logic fuses_loaded, wr_system_on_charge_enable, wr_off_state_charge_enable;
	logic wr_charge_target_code, wr_backup_rail_voltage_code, wr_data_bit;
	logic [3:0] charge_target_fuse_default, wr_code, charge_target_code;
	logic [1:0] backup_rail_voltage_fuse_code, wr_rail_code, backup_rail_voltage_code;
	logic [8:0] source_cv, charge_target_cv;
	logic system_on_charge_enable, off_state_charge_enable, charger_enable;
	logic charge_current_high, backup_rail_output, rail_from_main, rail_from_cell;
	logic rail_regulate, rail_dropout;
	backup_rail_pkg::power_state_t power_state;
	int n_fail = 0;
	int n_checks = 0;
	backup_charger_rail_control i_dut (.mclk, .rst, .power_state, .uv_ok_pin,
		.warn_low_pin, .main_above_cell_pin, .cell_present_pin, .fuses_loaded,
		.charge_target_fuse_default, .backup_rail_voltage_fuse_code, .source_cv,
		.wr_system_on_charge_enable, .wr_off_state_charge_enable, .wr_charge_target_code,
		.wr_backup_rail_voltage_code, .wr_data_bit, .wr_code, .wr_rail_code,
		.system_on_charge_enable, .off_state_charge_enable, .charge_target_code,
		.backup_rail_voltage_code, .charger_enable, .charge_current_high,
		.charge_target_cv, .backup_rail_output, .rail_from_main, .rail_from_cell,
		.rail_regulate, .rail_dropout);
	host_model u_host (.mclk, .wr_system_on_charge_enable, .wr_off_state_charge_enable,
		.wr_charge_target_code, .wr_backup_rail_voltage_code, .wr_data_bit, .wr_code,
		.wr_rail_code);
	// 4 ns clock
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	// expected charger target in tens of millivolts
	function automatic logic [8:0] tgt(input int c);
		return (c == 0) ? 9'h0B4 : (c == 15) ? 9'h168 : 9'(9'h0C8 + (c - 1) * 10);
	endfunction
	// generous wait: sync, store and derive stages are all shorter
	task automatic settle();
		repeat (8) @(negedge mclk);
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// the sequence needs well under 2000 cycles
	initial begin
		#20000;
		n_fail++;
		give_verdict();
	end
	initial begin
		rst = 1'b1;
		power_state = backup_rail_pkg::PS_RUN;
		{uv_ok_pin, warn_low_pin, main_above_cell_pin, cell_present_pin} = 4'h3;
		fuses_loaded = 1'b1;
		charge_target_fuse_default = 4'h5;
		backup_rail_voltage_fuse_code = 2'h2;
		source_cv = 9'h136; // 3.1 V source, below the 3.3 V setting only
		repeat (20) @(negedge mclk);
		rst = 1'b0;
		settle();
		`CHK(backup_rail_output, 1'b0)
		uv_ok_pin = 1'b1;
		settle();
		`CHK(charge_target_code, 4'h5)
		`CHK(backup_rail_voltage_code, 2'h2)
		`CHK(backup_rail_output, 1'b1)
		`CHK(rail_from_main, 1'b1)
		u_host.put(2'h0, 4'h1);
		settle();
		`CHK({charger_enable, charge_current_high}, 2'h3)
		power_state = backup_rail_pkg::PS_STANDBY;
		settle();
		`CHK({charger_enable, charge_current_high}, 2'h2)
		power_state = backup_rail_pkg::PS_OFF_OTHER;
		settle();
		`CHK(charger_enable, 1'b0)
		power_state = backup_rail_pkg::PS_QUIET_OFF;
		settle();
		`CHK(charger_enable, 1'b0)
		power_state = backup_rail_pkg::PS_RUN;
		u_host.put(2'h1, 4'h1);
		u_host.put(2'h0, 4'h0);
		settle();
		`CHK(charger_enable, 1'b0)
		power_state = backup_rail_pkg::PS_QUIET_OFF;
		settle();
		`CHK({charger_enable, charge_current_high}, 2'h2)
		power_state = backup_rail_pkg::PS_RUN;
		for (int i = 0; i < 16; i++) begin
			u_host.put(2'h2, 4'(i));
			settle();
			`CHK(charge_target_cv, tgt(i))
		end
		for (int i = 0; i < 4; i++) begin
			u_host.put(2'h3, 4'(i));
			settle();
			`CHK(backup_rail_voltage_code, 2'(i))
			`CHK(backup_rail_output, 1'(i != 0))
			`CHK(rail_dropout, 1'(i == 3))
		end
		// a rail write outside run and standby is dropped
		power_state = backup_rail_pkg::PS_QUIET_OFF;
		u_host.put(2'h3, 4'h1);
		settle();
		`CHK(backup_rail_voltage_code, 2'h3)
		power_state = backup_rail_pkg::PS_RUN;
		{warn_low_pin, main_above_cell_pin} = 2'h2;
		for (int i = 1; i < 4; i += 2) begin
			u_host.put(2'h3, 4'(i));
			settle();
			`CHK(rail_from_cell, 1'b1)
			`CHK(rail_regulate, 1'(i == 1))
		end
		power_state = backup_rail_pkg::PS_OFF_OTHER;
		main_above_cell_pin = 1'b1;
		settle();
		`CHK(backup_rail_output, 1'b1)
		`CHK(rail_from_main, 1'b1)
		u_host.put(2'h0, 4'h1);
		u_host.put(2'h1, 4'h1);
		uv_ok_pin = 1'b0;
		settle();
		`CHK({system_on_charge_enable, off_state_charge_enable}, 2'h0)
		`CHK(backup_rail_voltage_code, 2'h2)
		`CHK(backup_rail_output, 1'b1)
		// supply gone and cell now higher: rail stays up as a switch from the cell
		main_above_cell_pin = 1'b0;
		settle();
		`CHK(rail_from_cell, 1'b1)
		`CHK(rail_regulate, 1'b0)
		`CHK(backup_rail_output, 1'b1)
		// values written while the supply is low give way to the fuses on return
		power_state = backup_rail_pkg::PS_RUN;
		u_host.put(2'h3, 4'h1);
		u_host.put(2'h2, 4'h9);
		u_host.put(2'h0, 4'h1);
		{uv_ok_pin, warn_low_pin} = 2'h2;
		settle();
		`CHK(backup_rail_voltage_code, 2'h2)
		`CHK(charge_target_code, 4'h5)
		`CHK(system_on_charge_enable, 1'b0)
		`CHK(rail_from_main, 1'b1)
		`CHK(rail_regulate, 1'b1)
		give_verdict();
	end
endmodule // tb_top
